// [common/uip_pkg.sv]
package uip_pkg;
   // register indices; the byte address is four times the index
   localparam logic [3:0] IDX_DATA      = 4'h0;   // receive holding read, transmit holding write
   localparam logic [3:0] IDX_IER       = 4'h1;
   localparam logic [3:0] IDX_ISR_FCR   = 4'h2;   // status read, fifo control write
   localparam logic [3:0] IDX_LSR       = 4'h5;
   localparam logic [3:0] IDX_MSR       = 4'h6;
   localparam logic [3:0] IDX_EFR       = 4'h8;   // enhanced feature register
   localparam int         ADDR_LSB      = 2;
   localparam int         ADDR_W        = 6;

   // interrupt enable bit positions
   localparam int IE_RXDATA = 0;
   localparam int IE_TX_READY_EVENT  = 1;
   localparam int IE_LINE   = 2;
   localparam int IE_MODEM  = 3;
   localparam int IE_SLEEP  = 4;
   localparam int IE_XOFF   = 5;
   localparam int IE_RTS    = 6;
   localparam int IE_CTS    = 7;
   localparam logic [7:0] IER_RESET     = 8'h00;
   localparam logic [7:0] IER_BASE_MASK = 8'h0f;   // bits writable without enhanced mode

   // fifo control and enhanced feature fields
   localparam int FC_ENABLE = 0;
   localparam int FC_RXRST  = 1;
   localparam int FC_TXRST  = 2;
   localparam int FC_TXTRIG = 4;
   localparam int FC_RXTRIG = 6;
   localparam int EF_ENH    = 4;
   localparam int EF_ARTS   = 6;
   localparam int EF_ACTS   = 7;
   localparam logic [7:0] FCR_RESET = 8'h00;
   localparam logic [7:0] EFR_RESET = 8'h00;

   // six-bit interrupt source codes, highest priority first
   localparam logic [5:0] CODE_LINE    = 6'h06;
   localparam logic [5:0] CODE_TIMEOUT = 6'h0c;
   localparam logic [5:0] CODE_RXDATA  = 6'h04;
   localparam logic [5:0] CODE_TX_READY_EVENT   = 6'h02;
   localparam logic [5:0] CODE_MODEM   = 6'h00;
   localparam logic [5:0] CODE_XOFF    = 6'h10;
   localparam logic [5:0] CODE_FLOW    = 6'h20;
   localparam logic [5:0] CODE_NONE    = 6'h01;   // also wake-up

   // fifo trigger levels selected by a two-bit field
   localparam logic [4:0] TRIG_0 = 5'h01;
   localparam logic [4:0] TRIG_1 = 5'h04;
   localparam logic [4:0] TRIG_2 = 5'h08;
   localparam logic [4:0] TRIG_3 = 5'h0e;

   // receive timeout: four characters plus twelve bit times
   localparam int TIMEOUT_CHARS = 4;
   localparam int TIMEOUT_BITS  = 12;
endpackage

// [design/uip_intr_logic.sv]
// Decided for this implementation: the APB register port and the address map.
`timescale 1ns/10ps
module uip_intr_logic #(
   parameter int CNT_W     = 5,    // fifo level counter width
   parameter int CHAR_BITS = 10    // bit times per character frame
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic                  pslverr,
   output logic      [31:0]      prdata,
   // receive datapath
   input  wire logic [7:0]       rxData,
   input  wire logic [CNT_W-1:0] rxCount,
   input  wire logic             rxPush,
   input  wire logic             rxOverrun,
   input  wire logic [2:0]       rxHeadErr,
   input  wire logic             rxFifoErrAny,
   input  wire logic             bitTick,
   // transmit datapath
   input  wire logic [CNT_W-1:0] txCount,
   input  wire logic             thrEmpty,
   input  wire logic             txAllEmpty,
   // flow control, sleep and pins
   input  wire logic             xoffDetect,
   input  wire logic             xonDetect,
   input  wire logic             specialDetect,
   input  wire logic             rtsOut,
   input  wire logic             wakeEvent,
   input  wire logic             ctsPin,
   input  wire logic             dsrPin,
   input  wire logic             riPin,
   input  wire logic             cdPin,
   // outputs to datapath
   output logic                  irq,
   output logic                  sleepModeEn,
   output logic                  rxReadPulse,
   output logic                  thrWritePulse,
   output logic      [7:0]       thrData,
   output logic                  rxFifoReset,
   output logic                  txFifoReset,
   output logic                  fifoEnable,
   output logic                  autoRtsEn,
   output logic                  autoCtsEn
);
   localparam int TO_LIMIT = uip_pkg::TIMEOUT_CHARS * CHAR_BITS + uip_pkg::TIMEOUT_BITS;

   // refuse widths the counters and trigger compare cannot serve
   if (CNT_W < 5 || CNT_W > 16 || CHAR_BITS < 7 || CHAR_BITS > 12) begin : gBadParam
      $error("uip_intr_logic: unsupported parameter values");
   end

   logic [7:0]  ier_q, fcr_q, efr_q, rdData_q;
   logic [5:0]  rdCode_q;
   logic [3:0]  pinMeta_q, pinSync_q, pinPrev_q, delta_q;
   logic [2:0]  charErr_q;
   logic [15:0] toCnt_q;
   logic        overrun_q, timeout_q, tx_ready_event_q, txCondPrev_q, ieTxPrev_q, xoff_q;
   logic        special_q, flow_q, rtsPrev_q, wake_q, rdPend_q;

   // bus strobes
   localparam int ADDR_LSB_HI = uip_pkg::ADDR_LSB + 3;
   logic [3:0]  idx;
   logic        access, wr, rd, mapped, enh;
   assign idx    = paddr[ADDR_LSB_HI:uip_pkg::ADDR_LSB];
   assign mapped = (paddr[31:ADDR_LSB_HI+1] == '0) && (paddr[1:0] == 2'b00) &&
                   (idx == uip_pkg::IDX_DATA || idx == uip_pkg::IDX_IER ||
                    idx == uip_pkg::IDX_ISR_FCR || idx == uip_pkg::IDX_LSR ||
                    idx == uip_pkg::IDX_MSR || idx == uip_pkg::IDX_EFR);
   assign access = psel & penable;
   assign wr     = access & pwrite & mapped;
   assign rd     = access & ~pwrite & mapped;
   assign pready  = access & rdPend_q;
   assign pslverr = access & rdPend_q & ~mapped;
   assign enh    = efr_q[uip_pkg::EF_ENH];

   // effective enables: upper bits only count in enhanced mode
   logic [7:0]  ieEff;
   assign ieEff = enh ? ier_q : (ier_q & uip_pkg::IER_BASE_MASK);

   // trigger level lookup
   function automatic logic [4:0] trigLevel(input logic [1:0] sel);
      unique case (sel)
         2'b00: trigLevel = uip_pkg::TRIG_0;
         2'b01: trigLevel = uip_pkg::TRIG_1;
         2'b10: trigLevel = uip_pkg::TRIG_2;
         default: trigLevel = uip_pkg::TRIG_3;
      endcase
   endfunction

   logic [CNT_W-1:0] rxTrig, txTrig;
   assign rxTrig = CNT_W'(trigLevel(fcr_q[uip_pkg::FC_RXTRIG +: 2]));
   assign txTrig = CNT_W'(trigLevel(fcr_q[uip_pkg::FC_TXTRIG +: 2]));

   // source conditions
   logic dataReady, rxLevel, txCond, lineCond, modemCond;
   assign dataReady = (rxCount != '0);
   assign rxLevel   = fifoEnable ? (rxCount >= rxTrig) : dataReady;
   assign txCond    = fifoEnable ? (txCount < txTrig) : thrEmpty;
   assign lineCond  = overrun_q | (charErr_q != 3'b000);
   assign modemCond = (delta_q != 4'h0);

   // pending sources after enables; wake-up needs no enable
   logic pLine, pTo, pRx, pTx, pMod, pXoff, pFlow;
   assign pLine = ieEff[uip_pkg::IE_LINE] & lineCond;
   assign pTo   = ieEff[uip_pkg::IE_RXDATA] & timeout_q;
   assign pRx   = ieEff[uip_pkg::IE_RXDATA] & rxLevel;
   assign pTx   = ieEff[uip_pkg::IE_TX_READY_EVENT] & tx_ready_event_q;
   assign pMod  = ieEff[uip_pkg::IE_MODEM] & modemCond;
   assign pXoff = ieEff[uip_pkg::IE_XOFF] & (xoff_q | special_q);
   assign pFlow = (ieEff[uip_pkg::IE_RTS] | ieEff[uip_pkg::IE_CTS]) & flow_q;

   // priority encoder for the status code
   logic [5:0] code;
   always_comb begin
      if (pLine)      code = uip_pkg::CODE_LINE;
      else if (pTo)   code = uip_pkg::CODE_TIMEOUT;
      else if (pRx)   code = uip_pkg::CODE_RXDATA;
      else if (pTx)   code = uip_pkg::CODE_TX_READY_EVENT;
      else if (pMod)  code = uip_pkg::CODE_MODEM;
      else if (pXoff) code = uip_pkg::CODE_XOFF;
      else if (pFlow) code = uip_pkg::CODE_FLOW;
      else            code = uip_pkg::CODE_NONE;
   end

   // interrupt request
   assign irq = pLine | pTo | pRx | pTx | pMod | pXoff | pFlow | wake_q;

   // side-effect strobes, all taken at the access edge
   logic rdRhr, rdIsr, rdLsr, rdMsr, wrThr;
   assign rdRhr = rd & (idx == uip_pkg::IDX_DATA);
   assign rdIsr = rd & (idx == uip_pkg::IDX_ISR_FCR);
   assign rdLsr = rd & (idx == uip_pkg::IDX_LSR);
   assign rdMsr = rd & (idx == uip_pkg::IDX_MSR);
   assign wrThr = wr & (idx == uip_pkg::IDX_DATA);

   // line status and modem status views
   logic [7:0] lsrView, msrView;
   assign lsrView = {rxFifoErrAny, txAllEmpty, thrEmpty, charErr_q, overrun_q, dataReady};
   assign msrView = {pinSync_q[3], pinSync_q[2], pinSync_q[1], pinSync_q[0], delta_q};

   // read data mux, captured in the setup cycle
   logic [7:0] rdMux;
   always_comb begin
      unique case (idx)
         uip_pkg::IDX_DATA:    rdMux = rxData;
         uip_pkg::IDX_IER:     rdMux = ier_q;
         uip_pkg::IDX_ISR_FCR: rdMux = {fifoEnable, fifoEnable, code};
         uip_pkg::IDX_LSR:     rdMux = lsrView;
         uip_pkg::IDX_MSR:     rdMux = msrView;
         uip_pkg::IDX_EFR:     rdMux = efr_q;
         default:              rdMux = 8'h00;
      endcase
   end

   // setup cycle latches read data and the code it returns
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q <= 8'h00;
         rdCode_q <= uip_pkg::CODE_NONE;
         rdPend_q <= 1'b0;
      end else begin
         rdPend_q <= psel & ~penable;
         if (psel && !penable) begin
            rdData_q <= mapped ? rdMux : 8'h00;
            rdCode_q <= code;
         end
      end
   end
   assign prdata = {24'h000000, rdData_q};

   // control registers
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ier_q <= uip_pkg::IER_RESET;
         fcr_q <= uip_pkg::FCR_RESET;
         efr_q <= uip_pkg::EFR_RESET;
      end else if (wr && pready) begin
         if (idx == uip_pkg::IDX_IER) begin
            ier_q <= enh ? pwdata[7:0] : ((pwdata[7:0] & uip_pkg::IER_BASE_MASK) |
                                          (ier_q & ~uip_pkg::IER_BASE_MASK));
         end
         if (idx == uip_pkg::IDX_ISR_FCR && pwdata[uip_pkg::FC_ENABLE]) begin
            fcr_q[uip_pkg::FC_RXTRIG +: 2] <= pwdata[uip_pkg::FC_RXTRIG +: 2];
            if (enh) begin
               fcr_q[uip_pkg::FC_TXTRIG +: 2] <= pwdata[uip_pkg::FC_TXTRIG +: 2];
            end
         end
         if (idx == uip_pkg::IDX_ISR_FCR) begin
            fcr_q[uip_pkg::FC_ENABLE] <= pwdata[uip_pkg::FC_ENABLE];
         end
         if (idx == uip_pkg::IDX_EFR) begin
            efr_q <= pwdata[7:0];
         end
      end
   end
   assign fifoEnable  = fcr_q[uip_pkg::FC_ENABLE];
   assign autoRtsEn   = efr_q[uip_pkg::EF_ARTS];
   assign autoCtsEn   = efr_q[uip_pkg::EF_ACTS];
   assign sleepModeEn = ieEff[uip_pkg::IE_SLEEP];

   // datapath strobes and transmit data
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rxReadPulse   <= 1'b0;
         thrWritePulse <= 1'b0;
         thrData       <= 8'h00;
         rxFifoReset   <= 1'b0;
         txFifoReset   <= 1'b0;
      end else begin
         rxReadPulse   <= rdRhr & pready;
         thrWritePulse <= wrThr & pready;
         if (wrThr && pready) begin
            thrData <= pwdata[7:0];
         end
         rxFifoReset <= wr & pready & (idx == uip_pkg::IDX_ISR_FCR) &
                        pwdata[uip_pkg::FC_ENABLE] & pwdata[uip_pkg::FC_RXRST];
         txFifoReset <= wr & pready & (idx == uip_pkg::IDX_ISR_FCR) &
                        pwdata[uip_pkg::FC_ENABLE] & pwdata[uip_pkg::FC_TXRST];
      end
   end

   // modem pin synchronisers and delta flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         pinMeta_q <= 4'h0;
         pinSync_q <= 4'h0;
         pinPrev_q <= 4'h0;
         delta_q   <= 4'h0;
      end else begin
         pinMeta_q <= {cdPin, riPin, dsrPin, ctsPin};
         pinSync_q <= pinMeta_q;
         pinPrev_q <= pinSync_q;
         // a change in the clearing cycle still sets its delta
         delta_q <= ((rdMsr && pready) ? 4'h0 : delta_q) | (pinSync_q ^ pinPrev_q);
      end
   end

   // line status: overrun at once, char errors when the char is read out
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         overrun_q <= 1'b0;
         charErr_q <= 3'b000;
      end else begin
         overrun_q <= ((rdLsr && pready) ? 1'b0 : overrun_q) | rxOverrun;
         if (rdRhr && pready) begin
            charErr_q <= rxHeadErr | ((rdLsr && pready) ? 3'b000 : charErr_q);
         end else if (rdLsr && pready) begin
            charErr_q <= 3'b000;
         end
      end
   end

   // receive timeout timer counted in bit times
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         toCnt_q   <= 16'h0000;
         timeout_q <= 1'b0;
      end else begin
         if (rxPush || (rdRhr && pready) || !dataReady) begin
            toCnt_q <= 16'h0000;
         end else if (bitTick && toCnt_q < 16'(TO_LIMIT)) begin
            toCnt_q <= toCnt_q + 16'h0001;
         end
         if (rdRhr && pready) begin
            timeout_q <= 1'b0;
         end else if (dataReady && toCnt_q == 16'(TO_LIMIT)) begin
            timeout_q <= 1'b1;
         end
      end
   end

   // transmit ready event flag
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready_event_q      <= 1'b0;
         txCondPrev_q <= 1'b0;
         ieTxPrev_q   <= 1'b0;
      end else begin
         txCondPrev_q <= txCond;
         ieTxPrev_q   <= ier_q[uip_pkg::IE_TX_READY_EVENT];
         if ((txCond && !txCondPrev_q) ||
             (txCond && ier_q[uip_pkg::IE_TX_READY_EVENT] && !ieTxPrev_q)) begin
            tx_ready_event_q <= 1'b1;
         end else if ((wrThr && pready) ||
                      (rdIsr && pready && rdCode_q == uip_pkg::CODE_TX_READY_EVENT)) begin
            tx_ready_event_q <= 1'b0;
         end
      end
   end

   // xoff, special character, flow control and wake-up flags
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         xoff_q    <= 1'b0;
         special_q <= 1'b0;
         flow_q    <= 1'b0;
         rtsPrev_q <= 1'b0;
         wake_q    <= 1'b0;
      end else begin
         rtsPrev_q <= rtsOut;
         if (xoffDetect) begin
            xoff_q <= 1'b1;
         end else if (xonDetect ||
                      (rdIsr && pready && rdCode_q == uip_pkg::CODE_XOFF)) begin
            xoff_q <= 1'b0;
         end
         if (specialDetect) begin
            special_q <= 1'b1;
         end else if (rxPush ||
                      (rdIsr && pready && rdCode_q == uip_pkg::CODE_XOFF)) begin
            special_q <= 1'b0;
         end
         if ((autoRtsEn && rtsOut && !rtsPrev_q) ||
             (autoCtsEn && pinSync_q[0] && !pinPrev_q[0])) begin
            flow_q <= 1'b1;
         end else if (rdMsr && pready) begin
            flow_q <= 1'b0;
         end
         if (wakeEvent) begin
            wake_q <= 1'b1;
         end else if (rdIsr && pready && rdCode_q == uip_pkg::CODE_NONE) begin
            wake_q <= 1'b0;
         end
      end
   end
endmodule

// [verification/uip_intr_logic_sva.sv]
`timescale 1ns/10ps
module uip_intr_logic_sva #(
   parameter int CNT_W     = 5,
   parameter int CHAR_BITS = 10
) (
   // clock, reset and apb
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [31:0] prdata,
   // datapath side
   input wire logic        rxOverrun,
   input wire logic        dsrPin,
   input wire logic        irq,
   input wire logic        sleepModeEn,
   input wire logic        fifoEnable,
   input wire logic        rxReadPulse,
   input wire logic        thrWritePulse,
   input wire logic [7:0]  thrData,
   input wire logic        rxFifoReset,
   input wire logic        txFifoReset
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   logic [7:0] ierShadow_q;
   logic       enhShadow_q;
   logic       acc;
   // committed access phase
   assign acc = psel && penable && pready;
   // shadow of enable and enhanced bits, upper enables held without enhanced mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ierShadow_q <= 8'h00;
         enhShadow_q <= 1'b0;
      end else if (acc && pwrite && paddr[5:2] == uip_pkg::IDX_EFR) begin
         enhShadow_q <= pwdata[uip_pkg::EF_ENH];
      end else if (acc && pwrite && paddr[5:2] == uip_pkg::IDX_IER) begin
         ierShadow_q <= enhShadow_q ? pwdata[7:0] : {ierShadow_q[7:4], pwdata[3:0]};
      end
   end
   // read and write access steps
   sequence rd_acc(logic [3:0] idx);
      acc && !pwrite && paddr[5:2] == idx;
   endsequence
   sequence wr_acc(logic [3:0] idx);
      acc && pwrite && paddr[5:2] == idx;
   endsequence
   pready_phase_a: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   isr_fifo_a: assert property (
      rd_acc(uip_pkg::IDX_ISR_FCR) |-> prdata[7:6] == {2{fifoEnable}})
      else $error("status fifo bits wrong");
   isr_code_a: assert property (
      rd_acc(uip_pkg::IDX_ISR_FCR) |-> prdata[5:0] inside {6'h06, 6'h0c, 6'h04, 6'h02,
                                                           6'h00, 6'h10, 6'h20, 6'h01})
      else $error("illegal status code");
   pend_irq_a: assert property (
      rd_acc(uip_pkg::IDX_ISR_FCR) ##0 !prdata[0] |-> $past(irq))
      else $error("pending code without irq");
   reset_quiet_a: assert property ($rose(rst_n) |-> !irq && !sleepModeEn)
      else $error("enables active after reset");
   thr_write_a: assert property (
      wr_acc(uip_pkg::IDX_DATA) |=> thrWritePulse && thrData == $past(pwdata[7:0]))
      else $error("transmit write not passed on");
   rx_read_a: assert property (
      rd_acc(uip_pkg::IDX_DATA) |=> rxReadPulse ##1 !rxReadPulse)
      else $error("receive read pulse wrong");
   overrun_irq_a: assert property (
      rxOverrun && ierShadow_q[uip_pkg::IE_LINE] |=> irq)
      else $error("overrun did not raise irq");
   sleep_gate_a: assert property (
      sleepModeEn |-> enhShadow_q && ierShadow_q[uip_pkg::IE_SLEEP])
      else $error("sleep enable without enhanced mode");
   modem_irq_a: assert property (
      ierShadow_q[uip_pkg::IE_MODEM] && $rose(dsrPin) |-> ##[1:6] irq)
      else $error("modem change did not raise irq");
   fifo_reset_a: assert property (wr_acc(uip_pkg::IDX_ISR_FCR) |=>
      rxFifoReset == $past(pwdata[uip_pkg::FC_ENABLE] && pwdata[uip_pkg::FC_RXRST]) &&
      txFifoReset == $past(pwdata[uip_pkg::FC_ENABLE] && pwdata[uip_pkg::FC_TXRST]))
      else $error("fifo reset pulse wrong");
endmodule
bind uip_intr_logic uip_intr_logic_sva #(.CNT_W(CNT_W), .CHAR_BITS(CHAR_BITS))
   uip_intr_logic_sva_i (
   .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
   .rxOverrun(rxOverrun), .dsrPin(dsrPin), .irq(irq), .sleepModeEn(sleepModeEn),
   .fifoEnable(fifoEnable), .rxReadPulse(rxReadPulse), .thrWritePulse(thrWritePulse),
   .thrData(thrData), .rxFifoReset(rxFifoReset), .txFifoReset(txFifoReset)
);

// [verification/uip_host_model.sv]
`timescale 1ns/10ps
module uip_host_model (
   // clock
   input  wire logic        clk_sys,
   // apb master
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic      [31:0] paddr,
   output logic      [31:0] pwdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata
);
   // idle bus at time zero
   initial begin
      psel    = 1'b0;
      penable = 1'b0;
      pwrite  = 1'b0;
      paddr   = 32'h0;
      pwdata  = 32'h0;
   end
   // one transfer: setup after a rising edge, access held until pready
   task automatic xfer(input logic wr, input logic [3:0] idx, input logic [7:0] wd,
                       output logic [7:0] rd, output logic err);
      @(posedge clk_sys);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= {26'h0, idx, 2'b00};
      pwdata  <= {24'h0, wd};
      @(posedge clk_sys);
      penable <= 1'b1;
      // wait for the access edge; the bench watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata[7:0];
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      pwdata  <= ~pwdata;
   endtask
endmodule

// [verification/test_uip_intr_logic.sv]
`timescale 1ns/10ps
module test_uip_intr_logic;
   localparam int CHAR_BITS = 7;
   localparam int TMO       = 4 * CHAR_BITS + 12;   // bit ticks to receive timeout
   // clock, reset and apb
   logic        clk_sys, rst_n, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata;
   // datapath; ev bits: push, overrun, tick, xoff, xon, special, wake
   logic [6:0]  ev;
   logic [2:0]  headErr;
   logic        autoRtsEn, autoCtsEn;
   logic [4:0]  rxCount;
   logic [7:0]  rxData;
   logic        rxFifoErrAny, thrEmpty, txAllEmpty, rtsOut, ctsPin, dsrPin, irq, sleepModeEn;
   int          mismatches, checks_done;
   // design and host
   uip_intr_logic #(.CNT_W(5), .CHAR_BITS(CHAR_BITS)) uip_intr_logic_i (
      .clk_sys, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
      .rxData, .rxCount, .rxPush(ev[0]), .rxOverrun(ev[1]), .rxHeadErr(headErr), .rxFifoErrAny,
      .bitTick(ev[2]), .txCount(5'h00), .thrEmpty, .txAllEmpty, .xoffDetect(ev[3]),
      .xonDetect(ev[4]), .specialDetect(ev[5]), .rtsOut, .wakeEvent(ev[6]), .ctsPin, .dsrPin,
      .riPin(1'b0), .cdPin(1'b0), .irq, .sleepModeEn, .rxReadPulse(), .thrWritePulse(),
      .thrData(), .rxFifoReset(), .txFifoReset(), .fifoEnable(), .autoRtsEn, .autoCtsEn);
   uip_host_model uip_host_model_i (
      .clk_sys, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata);
   // system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   // byte compare
   task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [7:0] d);
      logic [7:0] r;
      logic       e;
      uip_host_model_i.xfer(1'b1, idx, d, r, e);
   endtask
   task automatic rd(input string what, input logic [3:0] idx, input logic [7:0] exp);
      logic [7:0] r;
      logic       e;
      uip_host_model_i.xfer(1'b0, idx, 8'h00, r, e);
      chk8(what, exp, r);
   endtask
   task automatic irq_is(input logic exp);
      #1;
      chk8("irq", {7'h00, exp}, {7'h00, irq});
      @(posedge clk_sys);
   endtask
   // one-cycle event, then let the flag settle
   task automatic pulse(input int b);
      @(posedge clk_sys);
      ev[b] <= 1'b1;
      @(posedge clk_sys);
      ev[b] <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic s_reset;
      logic [7:0] r;
      logic       e;
      rd("ier", uip_pkg::IDX_IER, 8'h00);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h01);
      uip_host_model_i.xfer(1'b0, 4'h3, 8'h00, r, e);
      chk8("unmapped", 8'h00, r);
      chk8("slverr", 8'h01, {7'h00, e});
      irq_is(1'b0);
   endtask
   task automatic s_enable;
      wr(uip_pkg::IDX_IER, 8'hff);
      rd("ier", uip_pkg::IDX_IER, 8'h0f);
      wr(uip_pkg::IDX_EFR, 8'h10);
      wr(uip_pkg::IDX_IER, 8'hf0);
      rd("ier", uip_pkg::IDX_IER, 8'hf0);
      chk8("sleep", 8'h01, {7'h00, sleepModeEn});
      wr(uip_pkg::IDX_IER, 8'h00);
      wr(uip_pkg::IDX_EFR, 8'h00);
   endtask
   task automatic s_line;
      wr(uip_pkg::IDX_IER, 8'h04);
      pulse(1);
      irq_is(1'b1);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h06);
      irq_is(1'b1);
      rxFifoErrAny <= 1'b1;
      rd("lsr", uip_pkg::IDX_LSR, 8'ha2);
      irq_is(1'b0);
      rd("lsr", uip_pkg::IDX_LSR, 8'ha0);
      rxFifoErrAny <= 1'b0;
      headErr <= 3'h2;
      irq_is(1'b0);
      rd("data", uip_pkg::IDX_DATA, 8'h5a);
      irq_is(1'b1);
      rd("lsr", uip_pkg::IDX_LSR, 8'h28);
      headErr <= 3'h0;
      wr(uip_pkg::IDX_IER, 8'h00);
   endtask
   task automatic s_prio;
      wr(uip_pkg::IDX_IER, 8'h0b);
      dsrPin <= 1'b1;
      rxCount <= 5'h01;
      pulse(0);
      repeat (4) @(posedge clk_sys);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h04);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h04);
      rd("data", uip_pkg::IDX_DATA, 8'h5a);
      rxCount <= 5'h00;
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h02);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h00);
      rd("msr", uip_pkg::IDX_MSR, 8'h22);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h01);
      thrEmpty <= 1'b0;
      repeat (2) @(posedge clk_sys);
      thrEmpty <= 1'b1;
      repeat (2) @(posedge clk_sys);
      irq_is(1'b1);
      wr(uip_pkg::IDX_DATA, 8'h33);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h01);
      wr(uip_pkg::IDX_IER, 8'h00);
   endtask
   task automatic s_fifo;
      wr(uip_pkg::IDX_ISR_FCR, 8'hc7);
      rxCount <= 5'h01;
      pulse(0);
      rd("lsr", uip_pkg::IDX_LSR, 8'h21);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'hc1);
      wr(uip_pkg::IDX_IER, 8'h01);
      repeat (TMO - 2) pulse(2);
      irq_is(1'b0);
      repeat (4) pulse(2);
      irq_is(1'b1);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'hcc);
      rd("data", uip_pkg::IDX_DATA, 8'h5a);
      repeat (2) @(posedge clk_sys);
      irq_is(1'b0);
      rxCount <= 5'h0e;
      repeat (3) @(posedge clk_sys);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'hc4);
      rxCount <= 5'h0d;
      repeat (3) @(posedge clk_sys);
      irq_is(1'b0);
      rxCount <= 5'h00;
      wr(uip_pkg::IDX_IER, 8'h00);
      wr(uip_pkg::IDX_ISR_FCR, 8'h00);
   endtask
   task automatic s_flow;
      wr(uip_pkg::IDX_EFR, 8'hd0);
      wr(uip_pkg::IDX_IER, 8'he0);
      chk8("auto", 8'h03, {6'h00, autoRtsEn, autoCtsEn});
      pulse(3);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h10);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h01);
      pulse(3);
      pulse(4);
      irq_is(1'b0);
      pulse(5);
      irq_is(1'b1);
      pulse(0);
      irq_is(1'b0);
      rtsOut <= 1'b1;
      repeat (3) @(posedge clk_sys);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h20);
      rd("msr", uip_pkg::IDX_MSR, 8'h20);
      irq_is(1'b0);
      ctsPin <= 1'b1;
      repeat (6) @(posedge clk_sys);
      irq_is(1'b1);
      rd("msr", uip_pkg::IDX_MSR, 8'h31);
      irq_is(1'b0);
      pulse(6);
      irq_is(1'b1);
      rd("isr", uip_pkg::IDX_ISR_FCR, 8'h01);
      irq_is(1'b0);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // main sequence
   initial begin
      {rst_n, ev, headErr, rxCount, rxFifoErrAny, txAllEmpty, rtsOut, ctsPin, dsrPin} = '0;
      {rxData, thrEmpty} = {8'h5a, 1'b1};
      {mismatches, checks_done} = '0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      s_reset;
      s_enable;
      s_line;
      s_prio;
      s_fifo;
      s_flow;
      close_out;
   end
   // hang guard
   initial begin
      #100000;
      mismatches++;
      close_out;
   end
endmodule
